// ### core/compare_timer_defines.vh
`ifndef COMPARE_TIMER_DEFINES_VH
`define COMPARE_TIMER_DEFINES_VH
// Register byte offsets
`define OFS_TIMER_CONTROL_ONE 5'h00
`define OFS_TIMER_CONTROL_TWO 5'h04
`define OFS_COMPARE_VALUE_A   5'h08
`define OFS_COMPARE_VALUE_B   5'h0C
`define OFS_COMPARE_VALUE_C   5'h10
`define OFS_TIMER_STATUS      5'h14
// Fields of timer_control_one
`define C1_RUN_BIT            0
`define C1_START_MODE_BIT     1
`define C1_EDGE_SELECT        2
`define C1_OPPOSITE_EDGE      3
`define C1_MODE_LO            4
`define C1_MODE_HI            5
`define C1_ONE_SHOT           6
`define C1_RESET_ALL          7
`define C1_START_OUTPUT       8
// Fields of timer_control_two
`define C2_INITIAL_LEVEL      0
`define C2_COUNT_LO           1
`define C2_COUNT_HI           2
`define C2_TRIGGER_DISABLE    3
`define C2_CLOCK_LO           4
`define C2_CLOCK_HI           6
`define C2_PRESCALER          7
// Fields of the status word
`define ST_RUNNING            16
`define ST_OUTPUT             17
// Operating modes
`define MODE_TIMER            2'h0
`define MODE_EVENT            2'h1
`define MODE_PULSE            2'h2
// Compare register count codes
`define COUNT_ONE             2'h0
`define COUNT_TWO             2'h1
`define COUNT_THREE           2'h2
// Reset values
`define RST_CONTROL_ONE       9'h000
`define RST_CONTROL_TWO       8'h00
`define RST_COMPARE           16'hFFFF
`endif

// ### core/compare_timer_trigger_event_pulse.v
// Behaviour
// - Trigger-start timer counts only after the selected active pin edge.
// - Continuous trigger timer: match A raises interrupt, clears, keeps counting.
// - Continuous trigger timer: trigger while counting stops; next one restarts.
// - One-shot trigger timer: match A interrupts, clears, stops until next trigger.
// - Trigger timer, opposite edge enabled: opposite pin edge clears and stops the counter.
// - Opposite edge disabled: opposite pin edges are ignored, except for the event mode match.
// - Event mode counts each active pin edge chosen by edge select.
// - Event mode: match A interrupts and clears, counting goes on.
// - Event match is taken on the opposite edge; source must keep toggling.
// - Pulse mode starts by command or pin edge, one or both edges.
// - Pulse mode: each match of an active compare register inverts output.
// - Pulse mode interrupt at the highest selected compare value.
// - Reset clears the output flip-flop to 0.
// - Initial level bit, XORed with the start output bit, gives the output's starting value.
// - Writes to compare B and C blocked unless pulse mode selects them.
// - Count field 00 selects A only, 01 selects A and B.
// - Single-shot pulse does not toggle at final match.
// - Active pin edges reset the counter in timer mode and triggered pulse mode while the trigger input is enabled.
// - Sixteen-bit up-counter advanced by the selected source clock.
// - Reset-all clears timer state and output; the interrupt stays low in that cycle.
// - Trigger disable forces the internal trigger to 0.
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`include "compare_timer_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module compare_timer_trigger_event_pulse #(
  parameter CNT_W = 16,
  parameter PRE_W = 12
) (
  // Clock and reset
  input  wire        MCLK_I,
  input  wire        RST_I,
  // Avalon-MM slave
  input  wire [4:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  output reg  [31:0] AVS_READDATA_O,
  output wire        AVS_WAITREQUEST_O,
  // Trigger pin and timer outputs
  input  wire        TRIGGER_INPUT_PIN_I,
  output reg         PULSE_PATTERN_OUTPUT_O,
  output reg         MATCH_INTERRUPT_O
);

////////////////////////////////////////////////////////////////////////////////
// Functions

  // Prescaler exponent for the source clock; 0 means no internal tick
  function [3:0] tick_exp;
    input [2:0] sel;
    input       div;
    begin
      case (sel)
        3'h0:    tick_exp = div ? 4'hC : 4'hB;
        3'h1:    tick_exp = div ? 4'h8 : 4'h7;
        3'h2:    tick_exp = div ? 4'h6 : 4'h5;
        3'h3:    tick_exp = div ? 4'h4 : 4'h3;
        3'h4:    tick_exp = div ? 4'h3 : 4'h2;
        3'h5:    tick_exp = div ? 4'h2 : 4'h1;
        default: tick_exp = 4'h0;
      endcase
    end
  endfunction

  // Byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] din;
    input [1:0]  be;
    begin
      merge16 = {be[1] ? din[15:8] : old[15:8], be[0] ? din[7:0] : old[7:0]};
    end
  endfunction

  // Larger of two compare values
  function [15:0] max16;
    input [15:0] a;
    input [15:0] b;
    begin
      max16 = (a > b) ? a : b;
    end
  endfunction

////////////////////////////////////////////////////////////////////////////////
// Register file

  reg  [8:0]       ctrl_one;
  reg  [7:0]       ctrl_two;
  reg  [15:0]      compare_value_a;
  reg  [15:0]      compare_value_b;
  reg  [15:0]      compare_value_c;
  reg              ack;
  reg              reset_all_bit;
  reg  [CNT_W-1:0] count;
  reg              running;
  reg              done;

  wire       run_bit              = ctrl_one[`C1_RUN_BIT];
  wire       start_mode_bit       = ctrl_one[`C1_START_MODE_BIT];
  wire       trigger_edge_select  = ctrl_one[`C1_EDGE_SELECT];
  wire       opposite_edge_enable = ctrl_one[`C1_OPPOSITE_EDGE];
  wire [1:0] mode                 = ctrl_one[`C1_MODE_HI:`C1_MODE_LO];
  wire       one_shot             = ctrl_one[`C1_ONE_SHOT];
  wire       start_output         = ctrl_one[`C1_START_OUTPUT];
  wire       output_initial_level = ctrl_two[`C2_INITIAL_LEVEL];
  wire [1:0] compare_count_field  = ctrl_two[`C2_COUNT_HI:`C2_COUNT_LO];
  wire       trigger_input_disable = ctrl_two[`C2_TRIGGER_DISABLE];
  wire [2:0] source_clock_select  = ctrl_two[`C2_CLOCK_HI:`C2_CLOCK_LO];
  wire       prescaler_select     = ctrl_two[`C2_PRESCALER];

  // B and C are usable only when pulse mode selects them
  wire use_b = (mode == `MODE_PULSE) &&
               ((compare_count_field == `COUNT_TWO) ||
                (compare_count_field == `COUNT_THREE));
  wire use_c = (mode == `MODE_PULSE) &&
               (compare_count_field == `COUNT_THREE);

  // One wait cycle per access keeps read data registered
  wire req = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req & ~ack;
  wire wr_go = AVS_WRITE_I & ack;

  // Acknowledge toggles so each request sees exactly one waited cycle
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Register writes; reset-all is a self-clearing strobe
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      ctrl_one        <= `RST_CONTROL_ONE;
      ctrl_two        <= `RST_CONTROL_TWO;
      compare_value_a <= `RST_COMPARE;
      compare_value_b <= `RST_COMPARE;
      compare_value_c <= `RST_COMPARE;
      reset_all_bit   <= 1'b0;
    end else begin
      reset_all_bit <= 1'b0;
      if (wr_go) begin
        case (AVS_ADDRESS_I)
          `OFS_TIMER_CONTROL_ONE: begin
            if (AVS_BYTEENABLE_I[0]) begin
              ctrl_one[7:0] <= {1'b0, AVS_WRITEDATA_I[6:0]};
              reset_all_bit <= AVS_WRITEDATA_I[`C1_RESET_ALL];
            end
            if (AVS_BYTEENABLE_I[1]) begin
              ctrl_one[8] <= AVS_WRITEDATA_I[`C1_START_OUTPUT];
            end
          end
          `OFS_TIMER_CONTROL_TWO: begin
            if (AVS_BYTEENABLE_I[0]) begin
              ctrl_two <= AVS_WRITEDATA_I[7:0];
            end
          end
          `OFS_COMPARE_VALUE_A: begin
            compare_value_a <= merge16(compare_value_a, AVS_WRITEDATA_I[15:0],
                                       AVS_BYTEENABLE_I[1:0]);
          end
          `OFS_COMPARE_VALUE_B: begin
            if (use_b) begin
              compare_value_b <= merge16(compare_value_b, AVS_WRITEDATA_I[15:0],
                                         AVS_BYTEENABLE_I[1:0]);
            end
          end
          `OFS_COMPARE_VALUE_C: begin
            if (use_c) begin
              compare_value_c <= merge16(compare_value_c, AVS_WRITEDATA_I[15:0],
                                         AVS_BYTEENABLE_I[1:0]);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read data captured in the waited cycle; unmapped reads give zero
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (AVS_READ_I && !ack) begin
      case (AVS_ADDRESS_I)
        `OFS_TIMER_CONTROL_ONE: AVS_READDATA_O <= {23'h000000, ctrl_one};
        `OFS_TIMER_CONTROL_TWO: AVS_READDATA_O <= {24'h000000, ctrl_two};
        `OFS_COMPARE_VALUE_A:   AVS_READDATA_O <= {16'h0000, compare_value_a};
        `OFS_COMPARE_VALUE_B:   AVS_READDATA_O <= {16'h0000, compare_value_b};
        `OFS_COMPARE_VALUE_C:   AVS_READDATA_O <= {16'h0000, compare_value_c};
        `OFS_TIMER_STATUS:      AVS_READDATA_O <= {14'h0000, PULSE_PATTERN_OUTPUT_O,
                                                   running, count};
        default:                AVS_READDATA_O <= 32'h0000_0000;
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Source clock and trigger edges

  reg  [PRE_W-1:0] pre_cnt;
  reg              trig_prev;

  // Free-running prescaler; a tick is the wrap of its low bits
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      pre_cnt <= {PRE_W{1'b0}};
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  wire [3:0]       exp_now  = tick_exp(source_clock_select, prescaler_select);
  wire [PRE_W-1:0] pre_mask = ({{(PRE_W-1){1'b0}}, 1'b1} << exp_now) - 1'b1;
  wire             tick     = (exp_now != 4'h0) &&
                              ((pre_cnt & pre_mask) == pre_mask);

  // Disabled trigger reads as a constant low
  wire trig_in = trigger_input_disable ? 1'b0 : TRIGGER_INPUT_PIN_I;

  always @(posedge MCLK_I) begin
    if (RST_I) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_in;
    end
  end

  wire rise     = trig_in & ~trig_prev;
  wire fall     = ~trig_in & trig_prev;
  wire act_edge = trigger_edge_select ? fall : rise;
  wire opp_edge = trigger_edge_select ? rise : fall;

////////////////////////////////////////////////////////////////////////////////
// Counter, output flip-flop and match interrupt

  wire [15:0] b_sel = use_b ? compare_value_b : 16'h0000;
  wire [15:0] c_sel = use_c ? compare_value_c : 16'h0000;
  wire [15:0] top   = max16(compare_value_a, max16(b_sel, c_sel));
  wire        hit_a   = (count == compare_value_a);
  wire        hit_any = hit_a || (use_b && count == compare_value_b) ||
                        (use_c && count == compare_value_c);
  wire        hit_top = (count == top);
  wire        start_level = output_initial_level ^ start_output;
  // Pulse trigger: active edge, or either edge when both are enabled
  wire        pulse_trig  = opposite_edge_enable ? (rise | fall) : act_edge;

  // Main timer engine; run bit low keeps everything idle
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      count                  <= {CNT_W{1'b0}};
      running                <= 1'b0;
      done                   <= 1'b0;
      PULSE_PATTERN_OUTPUT_O <= 1'b0;
      MATCH_INTERRUPT_O      <= 1'b0;
    end else begin
      MATCH_INTERRUPT_O <= 1'b0;
      if (reset_all_bit) begin
        // Interrupt pulse keeps the low default set above
        count                  <= {CNT_W{1'b0}};
        running                <= 1'b0;
        done                   <= 1'b0;
        PULSE_PATTERN_OUTPUT_O <= 1'b0;
      end else if (!run_bit) begin
        count                  <= {CNT_W{1'b0}};
        running                <= 1'b0;
        done                   <= 1'b0;
        PULSE_PATTERN_OUTPUT_O <= output_initial_level;
      end else begin
        case (mode)
          `MODE_TIMER: begin
            if (start_mode_bit) begin
              if (act_edge) begin
                count <= {CNT_W{1'b0}};
                // Continuous mode toggles run; one-shot always restarts
                running <= (running && !one_shot) ? 1'b0 : 1'b1;
              end else if (opp_edge && opposite_edge_enable) begin
                count   <= {CNT_W{1'b0}};
                running <= 1'b0;
              end else if (running && tick) begin
                if (hit_a) begin
                  MATCH_INTERRUPT_O <= 1'b1;
                  count             <= {CNT_W{1'b0}};
                  if (one_shot) begin
                    running <= 1'b0;
                  end
                end else begin
                  count <= count + 1'b1;
                end
              end
            end else begin
              running <= 1'b1;
              if (act_edge) begin
                count <= {CNT_W{1'b0}};
              end else if (tick) begin
                if (hit_a) begin
                  MATCH_INTERRUPT_O <= 1'b1;
                  count             <= {CNT_W{1'b0}};
                end else begin
                  count <= count + 1'b1;
                end
              end
            end
          end
          `MODE_EVENT: begin
            running <= 1'b1;
            if (act_edge) begin
              count <= count + 1'b1;
            end else if (opp_edge && hit_a) begin
              // Match only seen on the edge after the counting edge
              MATCH_INTERRUPT_O <= 1'b1;
              count             <= {CNT_W{1'b0}};
            end
          end
          `MODE_PULSE: begin
            if (start_mode_bit && pulse_trig) begin
              count                  <= {CNT_W{1'b0}};
              running                <= 1'b1;
              PULSE_PATTERN_OUTPUT_O <= start_level;
            end else if (!start_mode_bit && !running && !done) begin
              count                  <= {CNT_W{1'b0}};
              running                <= 1'b1;
              PULSE_PATTERN_OUTPUT_O <= start_level;
            end else if (running && tick) begin
              if (hit_any && !(one_shot && hit_top)) begin
                PULSE_PATTERN_OUTPUT_O <= ~PULSE_PATTERN_OUTPUT_O;
              end
              if (hit_top) begin
                MATCH_INTERRUPT_O <= 1'b1;
                count             <= {CNT_W{1'b0}};
                if (one_shot) begin
                  running <= 1'b0;
                  done    <= 1'b1;
                end
              end else begin
                count <= count + 1'b1;
              end
            end
          end
          default: begin
            running <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // compare_timer_trigger_event_pulse
`default_nettype wire

// ### test/compare_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module compare_timer_checker (
  // Clock and reset
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  // Register bus
  input wire logic [4:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0]  AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  // Timer outputs
  input wire logic        PULSE_PATTERN_OUTPUT_O,
  input wire logic        MATCH_INTERRUPT_O
);
  logic req;
  // Any bus request in flight
  assign req = AVS_READ_I | AVS_WRITE_I;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////////////////////////////////////////
  // A fresh request always sees one wait cycle
  property p_wait_first;
    req && !$past(req) |-> AVS_WAITREQUEST_O;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait on new request");
  // The wait lasts exactly one cycle
  property p_wait_one;
    req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
  // An idle bus never stalls
  property p_wait_idle;
    !req |-> !AVS_WAITREQUEST_O;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait raised while idle");
  // Interrupt is a single-cycle pulse
  property p_irq_pulse;
    MATCH_INTERRUPT_O |=> !MATCH_INTERRUPT_O;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt wider than a cycle");
  // Outputs leave reset cleared
  property p_reset_out;
    $fell(RST_I) |-> !PULSE_PATTERN_OUTPUT_O && !MATCH_INTERRUPT_O && AVS_READDATA_O == 32'h0;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
  // Reset-all strobe drives the pulse output low
  property p_reset_all;
    AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 5'h00 && AVS_BYTEENABLE_I[0]
      && AVS_WRITEDATA_I[7] |=> ##1 !PULSE_PATTERN_OUTPUT_O;
  endproperty
  a_reset_all: assert property (p_reset_all) else $error("output high after reset-all");
  // Unmapped places above the status word read as zero
  property p_unmapped;
    AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I > 5'h14 |-> AVS_READDATA_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Read data stands until the next read is captured
  property p_rd_stable;
    !AVS_READ_I |=> $stable(AVS_READDATA_O);
  endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved without a read");
endmodule // compare_timer_checker
bind compare_timer_trigger_event_pulse compare_timer_checker chk_i (.*);
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        MCLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdat;
  logic        wait_o, pin, pout, irq, pout_q;
  int          n_errors = 0;
  int          tests_run = 0;
  int          irqs = 0;
  int          togs = 0;
  logic [31:0] seed = 32'h9E6B;
  // Clock
  always #5 MCLK_I = ~MCLK_I;
  compare_timer_trigger_event_pulse compare_timer_trigger_event_pulse_i (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wait_o), .TRIGGER_INPUT_PIN_I(pin), .PULSE_PATTERN_OUTPUT_O(pout),
    .MATCH_INTERRUPT_O(irq));
  trigger_source_model trigger_source_model_i (.clk(MCLK_I), .pin(pin));
  // Tally interrupts and output inversions; the bench keeps snapshots, never clears
  always @(posedge MCLK_I) begin
    pout_q <= pout;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (pout !== pout_q && !RST_I) togs <= togs + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  // Only the watchdog ends a wait that never gets its answer
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] m, output logic [31:0] q);
    @(posedge MCLK_I);
    adr <= a;
    wdat <= d;
    be <= m;
    wr <= w;
    rd <= !w;
    do @(posedge MCLK_I); while (wait_o !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d, input logic [3:0] m = 4'hF);
    logic [31:0] q;
    bus(1'b1, a, d, m, q);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(q & m, e);
  endtask
  // Count is compared across ten idle clocks
  task automatic moving(input logic e);
    logic [31:0] q1, q2;
    bus(1'b0, 5'h14, 32'h0, 4'hF, q1);
    repeat (10) @(posedge MCLK_I);
    bus(1'b0, 5'h14, 32'h0, 4'hF, q2);
    chk({31'h0, q1[15:0] != q2[15:0]}, {31'h0, e});
  endtask
  // Settings change only with the timer idle
  task automatic cfg(input logic [8:0] c1, input logic [7:0] c2, input logic [15:0] a, b);
    wreg(5'h00, 32'h80);
    wreg(5'h00, {23'h0, c1 & 9'h1FC});
    wreg(5'h04, {24'h0, c2});
    wreg(5'h08, {16'h0, a});
    wreg(5'h0C, {16'h0, b});
    wreg(5'h10, {16'h0, b + 16'h4});
    wreg(5'h00, {23'h0, c1});
  endtask
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog, far beyond the few thousand clocks the tests need
  initial begin
    #400000;
    n_errors++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int i0, t0, av, ev;
    logic [31:0] rv;
    repeat (5) @(posedge MCLK_I);
    RST_I <= 1'b0;
    rdchk(5'h00, 32'h1FF, 32'h0);
    rdchk(5'h04, 32'hFF, 32'h0);
    for (int k = 0; k < 3; k++) rdchk(5'h08 + 5'(4 * k), 32'hFFFF, 32'hFFFF);
    rdchk(5'h18, 32'hFFFFFFFF, 32'h0);
    // Byte lanes of a compare value land one at a time
    rv = rnd();
    wreg(5'h08, rv, 4'h0);
    rdchk(5'h08, 32'hFFFF, 32'hFFFF);
    wreg(5'h08, rv, 4'h1);
    rdchk(5'h08, 32'hFFFF, {16'h0, 8'hFF, rv[7:0]});
    wreg(5'h08, rv, 4'h2);
    rdchk(5'h08, 32'hFFFF, {16'h0, rv[15:0]});
    wreg(5'h0C, 32'h1234);
    rdchk(5'h0C, 32'hFFFF, 32'hFFFF);
    wreg(5'h00, 32'h20);
    wreg(5'h04, 32'h02);
    wreg(5'h0C, 32'h1234);
    wreg(5'h10, 32'h5678);
    rdchk(5'h0C, 32'hFFFF, 32'h1234);
    rdchk(5'h10, 32'hFFFF, 32'hFFFF);
    wreg(5'h04, 32'h04);
    wreg(5'h10, 32'h5678);
    rdchk(5'h10, 32'hFFFF, 32'h5678);
    $display("test registers done");
    // Event counting on either edge, match taken on the other one
    for (int es = 0; es < 2; es++) begin
      av = 3 + int'(rnd() % 4);
      cfg(9'h011 | 9'(es << 2), 8'h70, 16'(av), 16'hFFFF);
      i0 = irqs;
      t0 = 0;
      ev = 0;
      for (int p = 0; p < 2 * av + 1; p++) begin
        trigger_source_model_i.send(1);
        for (int e = 0; e < 2; e++) begin
          if (e == es) t0++;
          else if (t0 == av) begin
            t0 = 0;
            ev++;
          end
        end
        rdchk(5'h14, 32'hFFFF, 32'(t0));
      end
      chk(irqs - i0, ev);
    end
    $display("test event done");
    cfg(9'h003, 8'h50, 16'hFFFF, 16'hFFFF);
    moving(1'b0);
    trigger_source_model_i.send(1);
    moving(1'b1);
    trigger_source_model_i.send(1);
    moving(1'b0);
    trigger_source_model_i.send(1);
    moving(1'b1);
    cfg(9'h00B, 8'h50, 16'hFFFF, 16'hFFFF);
    trigger_source_model_i.send(1);
    moving(1'b0);
    rdchk(5'h14, 32'hFFFF, 32'h0);
    cfg(9'h003, 8'h58, 16'hFFFF, 16'hFFFF);
    trigger_source_model_i.send(1);
    moving(1'b0);
    cfg(9'h043, 8'h50, 16'h3, 16'hFFFF);
    i0 = irqs;
    trigger_source_model_i.send(1);
    repeat (100) @(posedge MCLK_I);
    chk(irqs - i0, 1);
    rdchk(5'h14, 32'hFFFF, 32'h0);
    trigger_source_model_i.send(1);
    repeat (100) @(posedge MCLK_I);
    chk(irqs - i0, 2);
    cfg(9'h003, 8'h50, 16'h3, 16'hFFFF);
    trigger_source_model_i.send(1);
    i0 = irqs;
    repeat (80) @(posedge MCLK_I);
    chk(32'(irqs - i0 >= 9 && irqs - i0 <= 11), 1);
    // New compare value written just after a match, before the next one
    do @(posedge MCLK_I); while (irq !== 1'b1);
    wreg(5'h08, 32'h7);
    i0 = irqs;
    repeat (80) @(posedge MCLK_I);
    chk(32'(irqs - i0 >= 4 && irqs - i0 <= 6), 1);
    $display("test trigger timer done");
    cfg(9'h021, 8'h5B, 16'h4, 16'h8);
    chk({31'h0, pout}, 1);
    i0 = irqs;
    t0 = togs;
    for (int k = 0; k < 500 && irqs - i0 < 3; k++) @(posedge MCLK_I);
    repeat (2) @(posedge MCLK_I);
    chk(togs - t0, 6);
    chk({31'h0, pout}, 1);
    cfg(9'h023, 8'h52, 16'h4, 16'h8);
    i0 = irqs;
    repeat (40) @(posedge MCLK_I);
    chk(irqs - i0, 0);
    trigger_source_model_i.send(1);
    repeat (60) @(posedge MCLK_I);
    chk(32'(irqs > i0), 1);
    cfg(9'h061, 8'h59, 16'h4, 16'h8);
    i0 = irqs;
    t0 = togs;
    repeat (60) @(posedge MCLK_I);
    chk(togs - t0, 0);
    chk(irqs - i0, 1);
    chk({31'h0, pout}, 1);
    // Three registers, start level inverted by the start output bit
    cfg(9'h121, 8'h5D, 16'h4, 16'h8);
    repeat (3) @(posedge MCLK_I);
    chk({31'h0, pout}, 0);
    i0 = irqs;
    t0 = togs;
    for (int k = 0; k < 500 && irqs - i0 < 2; k++) @(posedge MCLK_I);
    repeat (2) @(posedge MCLK_I);
    chk(togs - t0, 6);
    chk({31'h0, pout}, 0);
    $display("test pulse done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire

// ### test/trigger_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module trigger_source_model (
  // Clock
  input  wire logic clk,
  // Trigger pin, idles low between pulses
  output var  logic pin
);
  initial pin = 1'b0;
  // Each level is held six clocks, over the four-clock minimum
  // A trailing low always follows, so the match edge comes
  task automatic send(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      pin <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
endmodule // trigger_source_model
`default_nettype wire
